//--- irq_route_pkg.sv
// How it works
// - Pin judgement one state, peripheral zero
// - Instruction wait bounded by four plus accesses
// - Entry takes five plus three accesses
// - DMA-selected enabled sources withheld from controller
// - Set source enable blocks CPU request
// - Enable cleared by transfer end with qualifier
// - Flag cleared by end with select clear or DMA end
// - Qualifier is select bit or zero count
// - Select set: end clears enable, keeps flag
// - DMA selection masks CPU and transfer requests
// - DMA clears flag at its transfer
// - Select clear: each nonzero-count transfer clears flag only
// - Zero count clears enable, raises CPU request
// - Plain sources go straight to CPU
// - Forward only above the CPU mask level
package irq_route_pkg;
  localparam int N_SRC = 8;
  localparam int SRC_W = 3;
  localparam int N_CH = 4;
  localparam int LVL_W = 4;
  localparam int CNT_W = 8;
  // Sources 0..3 are external pins, the rest on-chip peripherals
  localparam logic [N_SRC-1:0] PIN_SRC_MASK = 8'h0f;
  // Memory access states: status save, PC save, vector fetch, first fetch
  localparam int M1 = 1;
  localparam int M2 = 1;
  localparam int M3 = 1;
  localparam int M4 = 1;
  localparam logic [CNT_W-1:0] WAIT_MAX_CYC = CNT_W'(4 + M1 + M2 + M3 + M4);
  localparam logic [CNT_W-1:0] ENTRY_CYC = CNT_W'(5 + M1 + M2 + M3);
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DMASEL_OFS = 8'h04;
  localparam logic [7:0] DTE_OFS = 8'h08;
  localparam logic [7:0] CPU_IRQ_AFTER_TRANSFER_SELECT_OFS = 8'h0c;
  localparam logic [7:0] FLAG_OFS = 8'h10;
  localparam logic [7:0] PRIO_OFS = 8'h14;
  localparam logic [7:0] LEVEL_OFS = 8'h18;
  localparam logic [7:0] CPUSTAT_OFS = 8'h1c;
  localparam logic [7:0] ISTAT_OFS = 8'h20;
  localparam logic [7:0] IMASK_OFS = 8'h24;
  // Field positions
  localparam int CTRL_DME_BIT = 0;
  localparam int CTRL_DE_LSB = 4;
  localparam int DMASEL_FIELD_W = 4;
  // Sticky event bits
  localparam int EV_DTC_IRQ = 0;
  localparam int EV_DTC_ZERO = 1;
  localparam int EV_DMA_END = 2;
  localparam int EV_CPU_ACC = 3;
  localparam int EV_W = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ENTRY = 3'b100
  } route_state_t;
endpackage

//--- resp_timer.sv
`timescale 1ns/10ps
module resp_timer
  import irq_route_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= count;
        busy <= 1'b1;
      end else if (busy) begin
        // Done pulses after exactly count states from the load edge
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // resp_timer

//--- route_slice.sv
`timescale 1ns/10ps
module route_slice (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_event,
  input wire logic dma_masked,
  input wire logic cpu_irq_after_transfer_select,
  input wire logic dte_wr,
  input wire logic dte_wdata,
  input wire logic flag_clr_wr,
  input wire logic dtc_end,
  input wire logic count_zero,
  input wire logic dma_end,
  output logic flag,
  output logic transfer_ctrl_source_enable,
  output logic end_req,
  output logic cpu_req,
  output logic dtc_act
);
  logic clear_qual;
  logic flag_clr;

  assign clear_qual = cpu_irq_after_transfer_select | count_zero;
  // Select set keeps the flag so the CPU sees the end; select clear drops it at every end
  assign flag_clr = (dtc_end & ~cpu_irq_after_transfer_select) | dma_end | flag_clr_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      // A new request in the clearing cycle is kept
      flag <= req_event | (flag & ~flag_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_ctrl_source_enable <= 1'b0;
    end else if (dte_wr) begin
      transfer_ctrl_source_enable <= dte_wdata;
    end else if (dtc_end & clear_qual) begin
      transfer_ctrl_source_enable <= 1'b0;
    end
  end

  // Zero count with select clear drops the flag, so the end request is held apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_req <= 1'b0;
    end else if (dtc_end & count_zero & ~cpu_irq_after_transfer_select) begin
      end_req <= 1'b1;
    end else if (flag_clr_wr) begin
      end_req <= 1'b0;
    end
  end

  assign cpu_req = (flag | end_req) & ~transfer_ctrl_source_enable & ~dma_masked;
  assign dtc_act = flag & transfer_ctrl_source_enable & ~dma_masked;

  dte_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!dte_wr && dtc_end && clear_qual) |=> !transfer_ctrl_source_enable)
    else $error("enable not cleared after qualified end");
  dte_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!dte_wr && transfer_ctrl_source_enable && !(dtc_end && clear_qual)) |=> transfer_ctrl_source_enable)
    else $error("enable dropped without qualified end");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_end && !req_event) |=> !flag)
    else $error("flag survived transfer end");
  flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flag && dtc_end && cpu_irq_after_transfer_select && !count_zero && !flag_clr_wr && !dma_end) |=> flag)
    else $error("flag lost in select mode");
endmodule // route_slice

//--- irq_route.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module irq_route
  import irq_route_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_route_pkg::N_SRC-1:0] src_req,
  input wire logic dtc_end,
  input wire logic [irq_route_pkg::SRC_W-1:0] dtc_end_src,
  input wire logic dtc_count_zero,
  input wire logic [irq_route_pkg::N_CH-1:0] dma_end,
  input wire logic cpu_instr_done,
  output logic [irq_route_pkg::N_SRC-1:0] dtc_act,
  output logic [irq_route_pkg::N_CH-1:0] dma_act,
  output logic cpu_irq,
  output logic [irq_route_pkg::LVL_W-1:0] cpu_irq_level,
  output logic [irq_route_pkg::SRC_W-1:0] cpu_irq_src,
  output logic request_accepted_out_n,
  output logic handler_fetch,
  output logic irq
);
  import irq_route_pkg::*;

  logic dma_master_enable;
  logic [N_CH-1:0] dma_channel_enable;
  logic [N_CH*DMASEL_FIELD_W-1:0] dmasel_reg;
  logic [N_SRC-1:0] cpu_irq_after_transfer_select_reg;
  logic [N_SRC*LVL_W-1:0] prio_reg;
  logic [LVL_W-1:0] cpu_mask_level;
  logic [EV_W-1:0] istat_reg;
  logic [EV_W-1:0] imask_reg;
  logic [N_SRC-1:0] sync1_reg;
  logic [N_SRC-1:0] sync2_reg;
  logic [N_SRC-1:0] sync_prev_reg;
  logic [N_SRC-1:0] judge_reg;
  logic [N_SRC-1:0] req_event;
  logic [N_SRC-1:0] flag;
  logic [N_SRC-1:0] transfer_ctrl_source_enable;
  logic [N_SRC-1:0] end_req;
  logic [N_SRC-1:0] cpu_req;
  logic [N_SRC-1:0] dtc_act_next;
  logic [N_SRC-1:0] dma_masked;
  logic [N_SRC-1:0] dma_end_src;
  logic [N_CH-1:0] dma_act_next;
  logic [LVL_W-1:0] best_level;
  logic [SRC_W-1:0] best_src;
  logic best_valid;
  logic cpu_irq_next;
  logic [EV_W-1:0] ev;
  logic setup_ph;
  logic done_ph;
  logic wr_done;
  logic rd_done;
  logic addr_ok;
  logic [31:0] rd_word;
  route_state_t state_reg;
  route_state_t state_next;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;
  logic [CNT_W-1:0] wait_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Request intake

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync_prev_reg <= '0;
      judge_reg <= '0;
    end else begin
      sync1_reg <= src_req;
      sync2_reg <= sync1_reg;
      sync_prev_reg <= sync2_reg;
      // Pins spend one judgement state; peripherals enter at once
      judge_reg <= sync2_reg & ~sync_prev_reg & PIN_SRC_MASK;
    end
  end

  // Peripheral requests are same-clock pulses and need no synchroniser
  assign req_event = judge_reg | (src_req & ~PIN_SRC_MASK);

  always_comb begin
    dma_masked = '0;
    dma_end_src = '0;
    dma_act_next = '0;
    for (int c = 0; c < N_CH; c++) begin
      if (dma_master_enable && dma_channel_enable[c]) begin
        dma_masked[dmasel_reg[c*DMASEL_FIELD_W +: SRC_W]] = 1'b1;
        dma_act_next[c] = flag[dmasel_reg[c*DMASEL_FIELD_W +: SRC_W]];
        if (dma_end[c]) begin
          dma_end_src[dmasel_reg[c*DMASEL_FIELD_W +: SRC_W]] = 1'b1;
        end
      end
    end
  end

  for (genvar s = 0; s < N_SRC; s++) begin : g_src
    route_slice u_slice (
      .pclk(pclk),
      .presetn(presetn),
      .req_event(req_event[s]),
      .dma_masked(dma_masked[s]),
      .cpu_irq_after_transfer_select(cpu_irq_after_transfer_select_reg[s]),
      .dte_wr(wr_done && paddr[7:0] == DTE_OFS),
      .dte_wdata(pwdata[s]),
      .flag_clr_wr(wr_done && paddr[7:0] == FLAG_OFS && !pwdata[s]),
      .dtc_end(dtc_end && dtc_end_src == SRC_W'(s)),
      .count_zero(dtc_count_zero),
      .dma_end(dma_end_src[s]),
      .flag(flag[s]),
      .transfer_ctrl_source_enable(transfer_ctrl_source_enable[s]),
      .end_req(end_req[s]),
      .cpu_req(cpu_req[s]),
      .dtc_act(dtc_act_next[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level selection and CPU request

  // Lowest index wins a tie in level
  always_comb begin
    best_level = '0;
    best_src = '0;
    best_valid = 1'b0;
    for (int s = N_SRC - 1; s >= 0; s--) begin
      if (cpu_req[s] && prio_reg[s*LVL_W +: LVL_W] >= best_level) begin
        best_level = prio_reg[s*LVL_W +: LVL_W];
        best_src = SRC_W'(s);
        best_valid = 1'b1;
      end
    end
  end

  assign cpu_irq_next = best_valid && best_level > cpu_mask_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq <= 1'b0;
      request_accepted_out_n <= 1'b1;
      cpu_irq_level <= '0;
      cpu_irq_src <= '0;
      dtc_act <= '0;
      dma_act <= '0;
    end else begin
      cpu_irq <= cpu_irq_next;
      request_accepted_out_n <= ~cpu_irq_next;
      cpu_irq_level <= best_level;
      cpu_irq_src <= best_src;
      dtc_act <= dtc_act_next;
      dma_act <= dma_act_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response sequence

  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    // The registered fetch flag adds one state, so the timer runs one short
    tmr_count = ENTRY_CYC - 8'h01;
    case (state_reg)
      ST_IDLE: begin
        if (cpu_irq) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Instruction end, or the longest sequence has run out
        if (cpu_instr_done || wait_cnt_reg == WAIT_MAX_CYC) begin
          state_next = ST_ENTRY;
          tmr_load = 1'b1;
        end
      end
      ST_ENTRY: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      wait_cnt_reg <= '0;
      handler_fetch <= 1'b0;
    end else begin
      state_reg <= state_next;
      handler_fetch <= state_reg == ST_ENTRY && tmr_done;
      wait_cnt_reg <= (state_reg == ST_WAIT) ? wait_cnt_reg + 8'h01 : 8'h00;
    end
  end

  resp_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .count(tmr_count),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, pready from a flop

  assign setup_ph = psel && penable && !pready;
  assign done_ph = psel && penable && pready;
  assign wr_done = done_ph && pwrite && addr_ok;
  assign rd_done = done_ph && !pwrite && addr_ok;
  assign addr_ok = paddr[31:8] == 24'h000000 && paddr[1:0] == 2'b00 && paddr[7:0] <= IMASK_OFS;

  always_comb begin
    rd_word = RESET_WORD;
    case (paddr[7:0])
      CTRL_OFS: rd_word = {24'h000000, dma_channel_enable, 3'b000, dma_master_enable};
      DMASEL_OFS: rd_word = {16'h0000, dmasel_reg};
      DTE_OFS: rd_word = {24'h000000, transfer_ctrl_source_enable};
      CPU_IRQ_AFTER_TRANSFER_SELECT_OFS: rd_word = {24'h000000, cpu_irq_after_transfer_select_reg};
      FLAG_OFS: rd_word = {16'h0000, end_req, flag};
      PRIO_OFS: rd_word = prio_reg;
      LEVEL_OFS: rd_word = {28'h0000000, cpu_mask_level};
      CPUSTAT_OFS: rd_word = {17'h00000, tmr_busy, state_reg, cpu_irq_src, cpu_irq_level, 3'b000, cpu_irq};
      ISTAT_OFS: rd_word = {28'h0000000, istat_reg};
      IMASK_OFS: rd_word = {28'h0000000, imask_reg};
      default: rd_word = RESET_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RESET_WORD;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      if (setup_ph && !pwrite) begin
        prdata <= addr_ok ? rd_word : RESET_WORD;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_master_enable <= 1'b0;
      dma_channel_enable <= '0;
      dmasel_reg <= '0;
      cpu_irq_after_transfer_select_reg <= '0;
      prio_reg <= '0;
      imask_reg <= '0;
    end else if (wr_done) begin
      case (paddr[7:0])
        CTRL_OFS: begin
          dma_master_enable <= pwdata[CTRL_DME_BIT];
          dma_channel_enable <= pwdata[CTRL_DE_LSB +: N_CH];
        end
        DMASEL_OFS: dmasel_reg <= pwdata[N_CH*DMASEL_FIELD_W-1:0];
        CPU_IRQ_AFTER_TRANSFER_SELECT_OFS: cpu_irq_after_transfer_select_reg <= pwdata[N_SRC-1:0];
        PRIO_OFS: prio_reg <= pwdata;
        IMASK_OFS: imask_reg <= pwdata[EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Entry copies the accepted level into the mask; this wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mask_level <= '0;
    end else if (tmr_load) begin
      cpu_mask_level <= cpu_irq_level;
    end else if (wr_done && paddr[7:0] == LEVEL_OFS) begin
      cpu_mask_level <= pwdata[LVL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events and interrupt line

  assign ev[EV_DTC_IRQ] = dtc_end && cpu_irq_after_transfer_select_reg[dtc_end_src];
  assign ev[EV_DTC_ZERO] = dtc_end && dtc_count_zero;
  assign ev[EV_DMA_END] = |dma_end_src;
  assign ev[EV_CPU_ACC] = tmr_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= '0;
      irq <= 1'b0;
    end else begin
      // An event in the reading cycle survives the read-clear
      istat_reg <= ev | ((rd_done && paddr[7:0] == ISTAT_OFS) ? 4'h0 : istat_reg);
      irq <= |((ev | ((rd_done && paddr[7:0] == ISTAT_OFS) ? 4'h0 : istat_reg)) & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  dma_withhold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_masked[best_src] && best_valid) |-> !cpu_req[best_src])
    else $error("DMA source reached CPU arbitration");
  dtc_withhold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(dtc_act_next & dma_masked)) |-> 1'b0)
    else $error("DMA source activated transfer controller");
  dte_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(cpu_req & transfer_ctrl_source_enable)) |-> 1'b0)
    else $error("enabled source requested CPU");
  mask_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_next |-> (best_level > cpu_mask_level) ##1 (cpu_irq && !request_accepted_out_n))
    else $error("request at or below mask level");
  pin_judge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2_reg[0] && !sync_prev_reg[0]) |=> req_event[0])
    else $error("pin judgement not one state");
  wait_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_WAIT |-> wait_cnt_reg <= WAIT_MAX_CYC)
    else $error("instruction wait overran");
  entry_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_load |-> ##8 (state_reg == ST_ENTRY && tmr_done) ##1 handler_fetch)
    else $error("entry time wrong");
  plain_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req_event[0] && !transfer_ctrl_source_enable[0] && !dma_masked[0]) |=> cpu_req[0])
    else $error("plain request did not reach CPU");
endmodule // irq_route

//--- far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic zero_cmd,
  input wire logic [irq_route_pkg::N_SRC-1:0] dtc_act,
  input wire logic [irq_route_pkg::N_CH-1:0] dma_act,
  output logic dtc_end,
  output logic [irq_route_pkg::SRC_W-1:0] dtc_end_src,
  output logic dtc_count_zero,
  output logic [irq_route_pkg::N_CH-1:0] dma_end,
  output logic cpu_instr_done
);
  import irq_route_pkg::*;
  logic [3:0] tick;
  ////////////////////////////////////////
  // The CPU finishes an instruction every 4 states, or every 7 when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 4'h0;
    end else begin
      tick <= (tick == (slow ? 4'h6 : 4'h3)) ? 4'h0 : tick + 4'h1;
    end
  end
  assign cpu_instr_done = (tick == 4'h3);
  ////////////////////////////////////////
  initial begin : dtc_eng
    int i;
    logic [SRC_W-1:0] s;
    dtc_end = 1'b0;
    dtc_end_src = '0;
    dtc_count_zero = 1'b0;
    forever begin
      @(posedge pclk);
      if (presetn && |dtc_act) begin
        for (i = N_SRC - 1; i >= 0; i--) begin
          if (dtc_act[i]) s = SRC_W'(i);
        end
        repeat (slow ? 4 : 0) @(posedge pclk);
        dtc_end <= 1'b1;
        dtc_end_src <= s;
        dtc_count_zero <= zero_cmd;
        @(posedge pclk);
        // Qualifiers mean nothing outside the pulse, so they flip rather than hold
        dtc_end <= 1'b0;
        dtc_end_src <= ~s;
        dtc_count_zero <= ~zero_cmd;
        repeat (3) @(posedge pclk);
      end
    end
  end
  initial begin : dma_eng
    logic [N_CH-1:0] c;
    dma_end = '0;
    forever begin
      @(posedge pclk);
      if (presetn && |dma_act) begin
        c = dma_act & (~dma_act + 1'b1);
        repeat (slow ? 3 : 0) @(posedge pclk);
        dma_end <= c;
        @(posedge pclk);
        dma_end <= '0;
        repeat (3) @(posedge pclk);
      end
    end
  end
endmodule // far_side_model

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import irq_route_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dtc_end, dtc_count_zero, cpu_instr_done;
  logic [31:0] paddr, pwdata, prdata;
  logic cpu_irq, request_accepted_out_n, handler_fetch, irq, slow, zero_cmd, bad, seen;
  logic [N_SRC-1:0] src_req, dtc_act;
  logic [N_CH-1:0] dma_end, dma_act;
  logic [SRC_W-1:0] dtc_end_src, cpu_irq_src;
  logic [LVL_W-1:0] cpu_irq_level, lvl;
  logic [31:0] exp_q[$], msk_q[$];
  logic err_q[$];
  int fails, checked, s, ch;

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  irq_route uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .dtc_end(dtc_end), .dtc_end_src(dtc_end_src), .dtc_count_zero(dtc_count_zero),
    .dma_end(dma_end), .cpu_instr_done(cpu_instr_done), .dtc_act(dtc_act), .dma_act(dma_act),
    .cpu_irq(cpu_irq), .cpu_irq_level(cpu_irq_level), .cpu_irq_src(cpu_irq_src),
    .request_accepted_out_n(request_accepted_out_n), .handler_fetch(handler_fetch), .irq(irq));
  far_side_model far (.pclk(pclk), .presetn(presetn), .slow(slow), .zero_cmd(zero_cmd),
    .dtc_act(dtc_act), .dma_act(dma_act), .dtc_end(dtc_end), .dtc_end_src(dtc_end_src),
    .dtc_count_zero(dtc_count_zero), .dma_end(dma_end), .cpu_instr_done(cpu_instr_done));

  ////////////////////////////////////////
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask
  // Expected answer is queued at setup; the monitor compares at the ready edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic [31:0] m, input logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    msk_q.push_back(m);
    err_q.push_back(er);
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {24'h000000, a}, d, 32'h0, 32'h0, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, {24'h000000, a}, 32'h0, e, m, 1'b0);
  endtask
  task pulse(input int n);
    @(posedge pclk);
    src_req <= N_SRC'(1) << n;
    @(posedge pclk);
    src_req <= '0;
  endtask
  task wait_for(input bit fetch);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      v = fetch ? handler_fetch : cpu_irq;
    end while (v !== 1'b1 && n < 60);
    check(fetch ? "handler_fetch" : "cpu_irq", {31'h0, v}, 32'h1);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check("pslverr", {31'h0, pslverr}, {31'h0, err_q.pop_front()});
      check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    fails++;
    give_verdict;
  end

  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, slow, zero_cmd} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    src_req = '0;
    fails = 0;
    checked = 0;
    void'($urandom(32'hd2a1));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS, 32'h0, 32'hffffffff);
    rd(FLAG_OFS, 32'h0, 32'hffffffff);
    apb(1'b0, 32'h0000_0028, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 32'h0000_0102, 32'h1, 32'h0, 32'h0, 1'b1);
    rd(CTRL_OFS, 32'h0, 32'hffffffff);
    wr(IMASK_OFS, 32'h8);
    // Plain source goes straight to the CPU, then its own level masks it
    s = $urandom_range(7, 4);
    lvl = LVL_W'($urandom_range(15, 1));
    wr(PRIO_OFS, 32'(lvl) << (4 * s));
    pulse(s);
    wait_for(1'b0);
    check("irq_src", 32'(cpu_irq_src), 32'(s));
    check("irq_level", 32'(cpu_irq_level), 32'(lvl));
    check("accept_n", {31'h0, request_accepted_out_n}, 32'h0);
    wait_for(1'b1);
    repeat (2) @(posedge pclk);
    check("cpu_irq", {31'h0, cpu_irq}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rd(ISTAT_OFS, 32'h8, 32'h8);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    rd(FLAG_OFS, 32'h1 << s, 32'hff);
    wr(FLAG_OFS, 32'h0);
    wr(LEVEL_OFS, 32'h0);
    // Pin source passes the synchroniser and the judgement state
    wr(PRIO_OFS, 32'h1);
    pulse(0);
    wait_for(1'b0);
    check("pin_src", 32'(cpu_irq_src), 32'h0);
    wait_for(1'b1);
    wr(FLAG_OFS, 32'h0);
    wr(LEVEL_OFS, 32'h0);
    // Transfer controller with select clear
    wr(PRIO_OFS, 32'h0030_0000);
    wr(DTE_OFS, 32'h20);
    pulse(5);
    repeat (30) @(posedge pclk);
    check("cpu_irq", {31'h0, cpu_irq}, 32'h0);
    rd(DTE_OFS, 32'h20, 32'hff);
    rd(FLAG_OFS, 32'h0, 32'hffff);
    zero_cmd <= 1'b1;
    pulse(5);
    repeat (30) @(posedge pclk);
    rd(DTE_OFS, 32'h0, 32'hff);
    rd(FLAG_OFS, 32'h2000, 32'hffff);
    rd(ISTAT_OFS, 32'ha, 32'hf);
    wr(FLAG_OFS, 32'h0);
    wr(LEVEL_OFS, 32'h0);
    zero_cmd <= 1'b0;
    // Select set, count nonzero, slow partner
    slow <= 1'b1;
    wr(CPU_IRQ_AFTER_TRANSFER_SELECT_OFS, 32'h20);
    wr(DTE_OFS, 32'h20);
    pulse(5);
    repeat (30) @(posedge pclk);
    rd(DTE_OFS, 32'h0, 32'hff);
    rd(ISTAT_OFS, 32'h1, 32'h1);
    wr(FLAG_OFS, 32'h0);
    wr(CPU_IRQ_AFTER_TRANSFER_SELECT_OFS, 32'h0);
    slow <= 1'b0;
    // DMA-selected source on every channel; only the DMA end event reaches irq
    wr(PRIO_OFS, 32'h0700_0000);
    wr(DTE_OFS, 32'h40);
    wr(IMASK_OFS, 32'h4);
    for (ch = 0; ch < N_CH; ch++) begin
      wr(DMASEL_OFS, 32'h6 << (4 * ch));
      wr(CTRL_OFS, 32'h1 | (32'h10 << ch));
      pulse(6);
      bad = 1'b0;
      seen = 1'b0;
      repeat (16) begin
        @(posedge pclk);
        bad = bad | cpu_irq | dtc_act[6];
        seen = seen | dma_act[ch];
      end
      check("masked", {31'h0, bad}, 32'h0);
      check("dma_act", {31'h0, seen}, 32'h1);
      rd(FLAG_OFS, 32'h0, 32'hff);
      check("irq", {31'h0, irq}, 32'h1);
      rd(ISTAT_OFS, 32'h4, 32'h4);
      @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h0);
    end
    give_verdict;
  end
endmodule // tb_top
